// ### pkg/dipc_pkg.sv
package dipc_pkg;
   // -------------------------------------------------------------
   // register selects and field layout
   // -------------------------------------------------------------
   localparam logic [0:0]  SEL_CONTROL    = 1'h0;
   localparam logic [0:0]  SEL_STATUS     = 1'h1;
   localparam int          REG_W          = 16;
   localparam int          FLAG_N         = 6;
   localparam int          IRQ_N          = 8;
   localparam int          FLAG_LSB       = 10;
   localparam int          IRQ_LSB        = 0;
   localparam logic [15:0] CONTROL_RESET  = 16'h0000;
   localparam logic [15:0] STATUS_RESET   = 16'h0000;
   localparam logic [5:0]  FLAG_RESET     = 6'h00;
   localparam logic [7:0]  IRQ_RESET      = 8'h00;
endpackage

// ### pkg/dipc_req_if.sv
interface dipc_req_if;
   logic [7:0] set_req;
   logic [7:0] clr_req;
   logic [7:0] pend;

   modport owner
   (
      input  set_req,
      input  clr_req,
      output pend
   );
   modport user
   (
      output set_req,
      output clr_req,
      input  pend
   );
endinterface

// ### verilog/dipc_req_bank.sv
// sticky request bits: set wins over clear
module dipc_req_bank
(
   // clock and reset
   input  wire logic  mclk,
   input  wire logic  rstn,
   // request bus
   dipc_req_if.owner  req
);
   logic [7:0] pend_q;
   logic [7:0] pend_d;

   assign pend_d   = req.set_req | (pend_q & ~req.clr_req);
   assign req.pend = pend_q;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         pend_q <= dipc_pkg::IRQ_RESET;
      else
         pend_q <= pend_d;
   end
endmodule

// ### verilog/dipc_flag_mailbox.sv
// Notes on behaviour
// - control bits 15..10 drive six flags to host
// - status bits 15..10 mirror host-written flags
// - status bits 7..0 show host-to-dsp requests
// - writing one acknowledges, clearing both copies, unless set in the same cycle
// - writing zero leaves request unchanged
// - reset clears both registers entirely
module dipc_flag_mailbox
#(
   parameter int FLAG_W = dipc_pkg::FLAG_N,
   parameter int IRQ_W  = dipc_pkg::IRQ_N
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // dsp register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [0:0]  reg_sel,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // host side
   input  wire logic [5:0]  host_to_dsp_flag,
   input  wire logic [7:0]  dsp_irq_set,
   input  wire logic [7:0]  host_irq_clear,
   output logic      [5:0]  dsp_to_host_flag,
   output logic      [7:0]  host_irq_request,
   output logic      [7:0]  dsp_irq_pending,
   // dsp interrupt lines
   output logic      [7:0]  dsp_irq_request
);
   // -------------------------------------------------------------
   // parameter checks
   // -------------------------------------------------------------
   // ports and the request carrier are laid out for the fixed widths

   if (FLAG_W != dipc_pkg::FLAG_N)
   begin : g_bad_flag_w
      $error("flag width must match the register layout");
   end

   if (IRQ_W != dipc_pkg::IRQ_N)
   begin : g_bad_irq_w
      $error("request width must match the register layout");
   end

   if (dipc_pkg::FLAG_LSB + FLAG_W > dipc_pkg::REG_W)
   begin : g_bad_flag_fit
      $error("flag field runs past the register");
   end

   if (dipc_pkg::IRQ_LSB + IRQ_W > dipc_pkg::FLAG_LSB)
   begin : g_bad_irq_fit
      $error("request field overlaps the flag field");
   end

   // -------------------------------------------------------------
   // field layout
   // -------------------------------------------------------------
   localparam int FH    = dipc_pkg::FLAG_LSB + FLAG_W - 1;
   localparam int IH    = dipc_pkg::IRQ_LSB + IRQ_W - 1;
   localparam int GAP_W = dipc_pkg::FLAG_LSB - IH - 1;

   // -------------------------------------------------------------
   // register select decode
   // -------------------------------------------------------------
   function automatic logic sel_hit
   (
      input logic [0:0] sel,
      input logic [0:0] code
   );
      sel_hit = (sel == code);
   endfunction

   logic        wr_ctl;
   logic        wr_sts;
   logic        rd_ctl;

   assign wr_ctl = reg_wr && sel_hit(reg_sel, dipc_pkg::SEL_CONTROL);
   assign wr_sts = reg_wr && sel_hit(reg_sel, dipc_pkg::SEL_STATUS);
   assign rd_ctl = sel_hit(reg_sel, dipc_pkg::SEL_CONTROL);

   // -------------------------------------------------------------
   // state and views
   // -------------------------------------------------------------
   logic [5:0]  flag_q;
   logic [5:0]  flag_d;
   logic [7:0]  hreq_q;
   logic [7:0]  hreq_d;
   logic [7:0]  hraise;
   logic [5:0]  hflag_q;
   logic [7:0]  dpend;
   logic [7:0]  dsp_irq_request_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [15:0] ctl_view;
   logic [15:0] sts_view;
   logic [15:0] rd_view;

   // -------------------------------------------------------------
   // control register: flags to host
   // -------------------------------------------------------------
   assign flag_d = wr_ctl ? reg_wdata[FH:dipc_pkg::FLAG_LSB] : flag_q;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         flag_q <= dipc_pkg::FLAG_RESET;
      else
         flag_q <= flag_d;
   end

   // -------------------------------------------------------------
   // control register: requests to host
   // -------------------------------------------------------------
   // a zero written here never clears; only the host clears
   assign hraise = wr_ctl ? reg_wdata[IH:dipc_pkg::IRQ_LSB]
                          : dipc_pkg::IRQ_RESET;

   for (genvar i = 0; i < IRQ_W; i++)
   begin : g_hreq
      // dsp raise wins over host clear
      assign hreq_d[i] = hraise[i] | (hreq_q[i] & ~host_irq_clear[i]);
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         hreq_q <= dipc_pkg::IRQ_RESET;
      else
         hreq_q <= hreq_d;
   end

   // -------------------------------------------------------------
   // status register: host flag mirror
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         hflag_q <= dipc_pkg::FLAG_RESET;
      else
         hflag_q <= host_to_dsp_flag;
   end

   // -------------------------------------------------------------
   // status register: requests from host
   // -------------------------------------------------------------
   dipc_req_if rq ();

   assign rq.set_req = dsp_irq_set;
   // ones acknowledge, zeros leave bits alone
   assign rq.clr_req = wr_sts ? reg_wdata[IH:dipc_pkg::IRQ_LSB]
                              : dipc_pkg::IRQ_RESET;
   assign dpend      = rq.pend;

   dipc_req_bank u_bank
   (
      .mclk (mclk),
      .rstn (rstn),
      .req  (rq.owner)
   );

   // -------------------------------------------------------------
   // dsp interrupt lines
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         dsp_irq_request_q <= dipc_pkg::IRQ_RESET;
      else
         dsp_irq_request_q <= dpend;
   end

   // -------------------------------------------------------------
   // read back
   // -------------------------------------------------------------
   // reserved bits read as zero
   assign ctl_view = {flag_q, {GAP_W{1'b0}}, hreq_q};
   assign sts_view = {hflag_q, {GAP_W{1'b0}}, dpend};
   assign rd_view  = rd_ctl ? ctl_view : sts_view;
   assign rdata_d  = reg_rd ? rd_view : rdata_q;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         rdata_q <= dipc_pkg::STATUS_RESET;
      else
         rdata_q <= rdata_d;
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign reg_rdata        = rdata_q;
   assign dsp_to_host_flag = flag_q;
   assign host_irq_request = hreq_q;
   assign dsp_irq_pending  = dpend;
   assign dsp_irq_request  = dsp_irq_request_q;
endmodule

// ### verification/dipc_monitor.sv
module dipc_monitor
(
   // watched ports
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [5:0]  host_to_dsp_flag,
   input wire logic [0:0]  reg_sel,
   input wire logic [15:0] reg_wdata,
   input wire logic [7:0]  dsp_irq_set,
   input wire logic [5:0]  dsp_to_host_flag,
   input wire logic [7:0]  host_irq_request,
   input wire logic [7:0]  dsp_irq_pending,
   input wire logic [7:0]  dsp_irq_request
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire cw = reg_wr && reg_sel == 1'h0;
   wire sw = reg_wr && reg_sel == 1'h1;
   wire sr = reg_rd && reg_sel == 1'h1;
   property p_mirror; sr && $past(rstn)
      |=> reg_rdata[15:10] == $past(host_to_dsp_flag, 2); endproperty
   property p_stat; sr |=> reg_rdata[7:0] == $past(dsp_irq_pending);
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bad");
   a_stat: assert property (p_stat) else $error("status req bad");
   sequence s_ack; sw && reg_wdata[0] && !dsp_irq_set[0]; endsequence
   property p_flag; cw |=> dsp_to_host_flag == $past(reg_wdata[15:10]);
   endproperty
   property p_req; cw && reg_wdata[7:0] == 8'hff |=> &host_irq_request;
   endproperty
   property p_ack; s_ack |=> !dsp_irq_pending[0]; endproperty
   property p_keep; sw && !reg_wdata[0] && dsp_irq_pending[0]
      |=> dsp_irq_pending[0]; endproperty
   property p_line; $rose(dsp_irq_pending[0]) |=> dsp_irq_request[0];
   endproperty
   property p_rst; disable iff (1'b0) !rstn |=> dsp_irq_pending == 8'h00
      && host_irq_request == 8'h00 && dsp_to_host_flag == 6'h00; endproperty
   a_flag: assert property (p_flag) else $error("flag bad");
   a_req: assert property (p_req) else $error("host req bad");
   a_ack: assert property (p_ack) else $error("ack bad");
   a_keep: assert property (p_keep) else $error("zero write bad");
   a_line: assert property (p_line) else $error("irq line bad");
   a_rst: assert property (p_rst) else $error("reset bad");
endmodule
bind dipc_flag_mailbox dipc_monitor u_mon (.mclk(mclk), .rstn(rstn),
   .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .host_to_dsp_flag(host_to_dsp_flag),
   .dsp_irq_set(dsp_irq_set), .dsp_to_host_flag(dsp_to_host_flag),
   .host_irq_request(host_irq_request), .dsp_irq_pending(dsp_irq_pending),
   .dsp_irq_request(dsp_irq_request));

// ### verification/dipc_host_model.sv
module dipc_host
(
   // bench commands
   input  wire logic [21:0] cmd,
   input  wire logic        mclk,
   // toward the block
   output logic      [5:0]  flag = 6'h00,
   output logic      [7:0]  irq_set = 8'h00,
   output logic      [7:0]  irq_clr = 8'h00
);
   always @(posedge mclk)
   begin
      flag <= cmd[21:16];
      irq_set <= cmd[15:8];
      irq_clr <= cmd[7:0];
   end
endmodule

// ### verification/dipc_flag_mailbox_tb_top.sv
module dipc_flag_mailbox_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [0:0]  sel = 1'h0;
   logic [15:0] wd = 16'h0000;
   logic [21:0] cmd = 22'h0;
   wire  [15:0] rdat;
   wire  [5:0]  hf, tf;
   wire  [7:0]  hs, hc, hr, dp, dr;
   int          errors = 0;
   int          n_tests = 0;
   dipc_host host (.mclk(mclk), .cmd(cmd), .flag(hf), .irq_set(hs),
      .irq_clr(hc));
   dipc_flag_mailbox uut (.mclk(mclk), .rstn(rstn), .reg_wr(wr), .reg_rd(rd),
      .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rdat), .host_to_dsp_flag(hf),
      .dsp_irq_set(hs), .host_irq_clear(hc), .dsp_to_host_flag(tf),
      .host_irq_request(hr), .dsp_irq_pending(dp), .dsp_irq_request(dr));
   initial forever #4 mclk = ~mclk;
   task chk(input string n, input logic [15:0] e, s);
      n_tests++;
      if (e !== s)
      begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task acc(input logic w, input logic [0:0] s, input logic [15:0] d);
      @(posedge mclk);
      wr <= w;
      rd <= !w;
      sel <= s;
      wd <= d;
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task t_ctl;
      acc(1'h0, 1'h1, 16'h0000);
      chk("stat", 16'h0000, rdat);
      acc(1'h1, 1'h0, 16'hffff);
      chk("flag", 16'h003f, {10'h000, tf});
      chk("hreq", 16'h00ff, {8'h00, hr});
      acc(1'h0, 1'h0, 16'h0000);
      chk("ctl", 16'hfcff, rdat);
      @(posedge mclk);
      cmd <= 22'h0000ff;
      acc(1'h0, 1'h0, 16'h0000);
      @(posedge mclk);
      cmd <= 22'h0;
      chk("hclr", 16'h0000, {8'h00, hr});
   endtask
   task t_stat;
      @(posedge mclk);
      cmd <= {6'h2a, 8'ha5, 8'h00};
      @(posedge mclk);
      cmd <= {6'h2a, 16'h0000};
      acc(1'h0, 1'h1, 16'h0000);
      chk("stat", 16'ha8a5, rdat);
      chk("line", 16'h00a5, {8'h00, dr});
      acc(1'h1, 1'h1, 16'h0000);
      acc(1'h1, 1'h1, 16'h0021);
      acc(1'h0, 1'h1, 16'h0000);
      chk("ack", 16'ha884, rdat);
      chk("pend", 16'h0084, {8'h00, dp});
   endtask
   task t_rst;
      @(posedge mclk);
      cmd <= 22'h0;
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      acc(1'h0, 1'h0, 16'h0000);
      chk("rctl", 16'h0000, rdat);
      chk("rflag", 16'h0000, {10'h000, tf});
      acc(1'h0, 1'h1, 16'h0000);
      chk("rsts", 16'h0000, rdat);
      chk("rline", 16'h0000, {8'h00, dr});
   endtask
   task give_verdict;
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_ctl;
      t_stat;
      t_rst;
      give_verdict;
   end
   initial
   begin
      repeat (500) @(posedge mclk);
      errors++;
      give_verdict;
   end
endmodule
